/* design/wrs_pkg.sv */
// package of register offsets, reset values and operation codes for the working register and stack block
package wrs_pkg;
  localparam logic [7:0] ADDR_SLICE_FIRST = 8'hD6; // first slice pointer
  localparam logic [7:0] ADDR_SLICE_SECOND = 8'hD7; // second slice pointer
  localparam logic [7:0] ADDR_SP_HIGH = 8'hD8; // stack pointer high byte
  localparam logic [7:0] ADDR_SP_LOW = 8'hD9; // stack pointer low byte
  localparam logic [7:0] ADDR_STACK_STATUS = 8'hF0; // block status (read only)
  localparam logic [7:0] RESET_SLICE_FIRST = 8'hC0; // selects C0..C7
  localparam logic [7:0] RESET_SLICE_SECOND = 8'hC8; // selects C8..CF
  localparam logic [3:0] WREG_PREFIX = 4'hC; // 8-bit working register marker
  localparam int SLICE_LSB = 3; // slice pointer bits below this are ignored
  localparam int SEL_BIT = 3; // operand bit choosing the pointer
  // stack operation codes from the sequencer
  typedef enum logic [3:0] {
    WRS_OP_NONE,
    WRS_OP_CALL,
    WRS_OP_RET,
    WRS_OP_INT,
    WRS_OP_INT_RETURN,
    WRS_OP_PUSH,
    WRS_OP_POP,
    WRS_OP_USER_PUSH_INCR,
    WRS_OP_USER_PUSH_DECR,
    WRS_OP_USER_POP_INCR,
    WRS_OP_USER_POP_DECR
  } wrs_op_t;
endpackage : wrs_pkg

/* design/wrs_addr_calc.sv */
// working register address formation from 4-bit and 8-bit operands
`timescale 1ns/1ps
module wrs_addr_calc (
  input wire logic [7:0] slice_first, // first slice pointer
  input wire logic [7:0] slice_second, // second slice pointer
  input wire logic [7:0] operand, // register operand
  input wire logic short_form, // operand is a 4-bit working reference
  output logic [7:0] reg_addr, // resolved register address
  output logic is_working // operand resolved through a slice pointer
);
  logic [3:0] nib; // working nibble
  logic [7:0] ptr; // chosen pointer
  // resolve operand combinationally
  always_comb begin
    nib = operand[3:0];
    is_working = short_form || (operand[7:4] == wrs_pkg::WREG_PREFIX);
    ptr = nib[wrs_pkg::SEL_BIT] ? slice_second : slice_first;
    if (is_working) begin
      // low pointer bits are dropped here, yet still kept in the register
      reg_addr = {ptr[7:wrs_pkg::SLICE_LSB], nib[2:0]};
    end else begin
      reg_addr = operand; // plain register address
    end
  end
endmodule : wrs_addr_calc

/* design/wrs_core.sv */
// working register pointers, address resolution and system/user stack pointer
`timescale 1ns/1ps
// Notes on behaviour
// - nibble msb picks first or second pointer
// - pointer upper five bits form address 7..3
// - operand low three bits form address 2..0
// - upper nibble 1100B means working reference
// - 8-bit form uses bit 3 to pick
// - call pushes pc, return pops pc
// - interrupt pushes pc and flags; return pops
// - predecrement on push, postincrement on pop
// - stack pointer bytes at D8H and D9H
// - stack pointer has no reset value
// - low byte carry or borrow hits high
// - high byte usable as general storage
// - four user stack push/pop variants
// - reset pointers select C0H and C8H slices
// - slice pointers mapped at D6H, D7H
module wrs_core (
  input wire logic clk, // 10 MHz core clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic clk_en, // clock enable, freezes all state when low unless reset is asserted
  input wire logic [7:0] reg_addr, // register bus address
  input wire logic [7:0] reg_wdata, // register bus write data
  input wire logic reg_wr, // register bus write strobe
  input wire logic reg_rd, // register bus read strobe
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  input wire logic [7:0] wr_operand, // working register operand
  input wire logic wr_short, // operand is a 4-bit form
  output logic [7:0] wr_addr, // registered resolved address
  output logic wr_is_working, // registered working flag
  input wire logic [3:0] stk_op, // stack operation request, one cycle
  input wire logic [15:0] stk_pc, // program counter to save
  input wire logic [7:0] stk_flags, // flags to save
  input wire logic [7:0] stk_data, // data byte to push
  input wire logic [7:0] user_ptr, // user stack pointer register value
  output logic [7:0] user_ptr_new, // updated user stack pointer
  output logic user_ptr_we, // user stack pointer write pulse
  output logic [15:0] mem_addr, // stack memory byte address
  output logic [7:0] mem_wdata, // stack memory write data
  output logic mem_we, // stack memory write pulse
  output logic mem_re, // stack memory read pulse
  input wire logic [7:0] mem_rdata, // stack memory data, one cycle after read
  output logic [15:0] pc_load, // restored program counter
  output logic pc_load_we, // program counter load pulse
  output logic [7:0] flags_load, // restored flags
  output logic flags_load_we, // flags load pulse
  output logic [7:0] pop_data, // popped data byte
  output logic pop_data_we, // popped data valid pulse
  output logic stk_busy // stack sequence in progress
);
  // stack sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_POP, ST_READ, ST_WAIT} wrs_st_t;

  logic [7:0] slice_first_r, slice_first_nxt; // first slice pointer
  logic [7:0] slice_second_r, slice_second_nxt; // second slice pointer
  logic [15:0] sp_r, sp_nxt; // stack pointer
  logic [7:0] rdata_r, rdata_nxt; // read data
  logic [7:0] waddr_r, waddr_nxt; // resolved address
  logic wwork_r, wwork_nxt; // working flag
  wrs_st_t st_r, st_nxt; // sequencer state
  logic busy_r, busy_nxt; // busy kept in its own flop so the port comes straight from one
  logic [2:0] cnt_r, cnt_nxt; // bytes left in sequence
  logic [3:0] op_r, op_nxt; // latched operation
  logic [31:0] sh_r, sh_nxt; // push bytes, next byte in bits 7..0
  logic [31:0] acc_r, acc_nxt; // popped bytes
  logic [15:0] maddr_r, maddr_nxt; // memory address
  logic [7:0] mwd_r, mwd_nxt; // memory write data
  logic mwe_r, mwe_nxt; // memory write pulse
  logic mre_r, mre_nxt; // memory read pulse
  logic [7:0] uptr_r, uptr_nxt; // user pointer result
  logic uwe_r, uwe_nxt; // user pointer write
  logic [15:0] pcl_r, pcl_nxt; // pc load
  logic pcwe_r, pcwe_nxt; // pc load pulse
  logic [7:0] fl_r, fl_nxt; // flags load
  logic flwe_r, flwe_nxt; // flags load pulse
  logic [7:0] pd_r, pd_nxt; // pop data
  logic pdwe_r, pdwe_nxt; // pop data pulse
  logic [7:0] calc_addr; // combinational resolved address
  logic calc_work; // combinational working flag
  logic sp_wr_user; // software writes a stack byte this cycle

  // shared address resolution
  wrs_addr_calc u_addr (
    .slice_first(slice_first_r),
    .slice_second(slice_second_r),
    .operand(wr_operand),
    .short_form(wr_short),
    .reg_addr(calc_addr),
    .is_working(calc_work)
  );

  // register file next values; a software stack pointer write in a push or pop cycle is lost
  // because the sequencer's stack update there overrides sp_nxt
  always_comb begin
    slice_first_nxt = slice_first_r;
    slice_second_nxt = slice_second_r;
    rdata_nxt = 8'h00;
    waddr_nxt = calc_addr;
    wwork_nxt = calc_work;
    sp_wr_user = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        wrs_pkg::ADDR_SLICE_FIRST: slice_first_nxt = reg_wdata;
        wrs_pkg::ADDR_SLICE_SECOND: slice_second_nxt = reg_wdata;
        wrs_pkg::ADDR_SP_HIGH, wrs_pkg::ADDR_SP_LOW: sp_wr_user = 1'b1;
        default: begin
          // unmapped addresses ignore writes
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        wrs_pkg::ADDR_SLICE_FIRST: rdata_nxt = slice_first_r;
        wrs_pkg::ADDR_SLICE_SECOND: rdata_nxt = slice_second_r;
        wrs_pkg::ADDR_SP_HIGH: rdata_nxt = sp_r[15:8];
        wrs_pkg::ADDR_SP_LOW: rdata_nxt = sp_r[7:0];
        wrs_pkg::ADDR_STACK_STATUS: rdata_nxt = {7'h00, st_r != ST_IDLE};
        default: rdata_nxt = 8'h00; // unmapped reads return zero
      endcase
    end
  end

  // stack sequencer next values
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    sh_nxt = sh_r;
    acc_nxt = acc_r;
    sp_nxt = sp_r;
    maddr_nxt = maddr_r;
    mwd_nxt = mwd_r;
    mwe_nxt = 1'b0;
    mre_nxt = 1'b0;
    uptr_nxt = uptr_r;
    uwe_nxt = 1'b0;
    pcl_nxt = pcl_r;
    pcwe_nxt = 1'b0;
    fl_nxt = fl_r;
    flwe_nxt = 1'b0;
    pd_nxt = pd_r;
    pdwe_nxt = 1'b0;
    if (sp_wr_user) begin
      // high byte is plain storage when the stack lives in the low byte
      if (reg_addr == wrs_pkg::ADDR_SP_HIGH) sp_nxt[15:8] = reg_wdata;
      else sp_nxt[7:0] = reg_wdata;
    end
    unique case (st_r)
      ST_IDLE: begin
        op_nxt = stk_op;
        acc_nxt = 32'h0000_0000;
        unique case (stk_op)
          wrs_pkg::WRS_OP_CALL: begin
            sh_nxt = {16'h0000, stk_pc[15:8], stk_pc[7:0]};
            cnt_nxt = 3'd2;
            st_nxt = ST_PUSH;
          end
          wrs_pkg::WRS_OP_INT: begin
            sh_nxt = {8'h00, stk_flags, stk_pc[15:8], stk_pc[7:0]};
            cnt_nxt = 3'd3;
            st_nxt = ST_PUSH;
          end
          wrs_pkg::WRS_OP_PUSH: begin
            sh_nxt = {24'h000000, stk_data};
            cnt_nxt = 3'd1;
            st_nxt = ST_PUSH;
          end
          wrs_pkg::WRS_OP_RET: begin
            cnt_nxt = 3'd2;
            st_nxt = ST_POP;
          end
          wrs_pkg::WRS_OP_INT_RETURN: begin
            cnt_nxt = 3'd3;
            st_nxt = ST_POP;
          end
          wrs_pkg::WRS_OP_POP: begin
            cnt_nxt = 3'd1;
            st_nxt = ST_POP;
          end
          wrs_pkg::WRS_OP_USER_PUSH_INCR, wrs_pkg::WRS_OP_USER_PUSH_DECR: begin
            // user stacks: pointer moves first, then the byte is written
            uptr_nxt = (stk_op == wrs_pkg::WRS_OP_USER_PUSH_INCR) ? user_ptr + 8'h01
                                                                  : user_ptr - 8'h01;
            uwe_nxt = 1'b1;
            maddr_nxt = {8'h00, uptr_nxt};
            mwd_nxt = stk_data;
            mwe_nxt = 1'b1;
          end
          wrs_pkg::WRS_OP_USER_POP_INCR, wrs_pkg::WRS_OP_USER_POP_DECR: begin
            uptr_nxt = (stk_op == wrs_pkg::WRS_OP_USER_POP_INCR) ? user_ptr + 8'h01
                                                                 : user_ptr - 8'h01;
            uwe_nxt = 1'b1;
            maddr_nxt = {8'h00, user_ptr};
            mre_nxt = 1'b1;
            cnt_nxt = 3'd1;
            st_nxt = ST_READ;
          end
          default: begin
            // no operation
          end
        endcase
      end
      ST_PUSH: begin
        // 16-bit decrement lets a low-byte borrow reach the high byte
        sp_nxt = sp_r - 16'h0001;
        maddr_nxt = sp_nxt;
        mwd_nxt = sh_r[7:0];
        mwe_nxt = 1'b1;
        sh_nxt = {8'h00, sh_r[31:8]};
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) st_nxt = ST_IDLE;
      end
      ST_POP: begin
        maddr_nxt = sp_r; // read at top, then step past it
        mre_nxt = 1'b1;
        sp_nxt = sp_r + 16'h0001;
        st_nxt = ST_READ;
      end
      ST_READ: begin
        // read strobe is on the port now; the memory answers one cycle later
        st_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // bytes come back in reverse push order: last pushed first
        acc_nxt = {acc_r[23:0], mem_rdata};
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) begin
          st_nxt = ST_IDLE;
          unique case (op_r)
            wrs_pkg::WRS_OP_RET: begin
              pcl_nxt = {acc_r[7:0], mem_rdata};
              pcwe_nxt = 1'b1;
            end
            wrs_pkg::WRS_OP_INT_RETURN: begin
              fl_nxt = acc_r[15:8];
              flwe_nxt = 1'b1;
              pcl_nxt = {acc_r[7:0], mem_rdata};
              pcwe_nxt = 1'b1;
            end
            default: begin
              pd_nxt = mem_rdata;
              pdwe_nxt = 1'b1;
            end
          endcase
        end else begin
          st_nxt = ST_POP;
        end
      end
    endcase
    busy_nxt = (st_nxt != ST_IDLE);
  end

  // register update; stack pointer left out of reset on purpose
  always_ff @(posedge clk) begin
    if (clk_en) begin
      sp_r <= sp_nxt;
      rdata_r <= rdata_nxt;
      waddr_r <= waddr_nxt;
      wwork_r <= wwork_nxt;
      sh_r <= sh_nxt;
      acc_r <= acc_nxt;
      maddr_r <= maddr_nxt;
      mwd_r <= mwd_nxt;
      uptr_r <= uptr_nxt;
      pcl_r <= pcl_nxt;
      fl_r <= fl_nxt;
      pd_r <= pd_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
    end
    if (!rst_b) begin
      slice_first_r <= wrs_pkg::RESET_SLICE_FIRST;
      slice_second_r <= wrs_pkg::RESET_SLICE_SECOND;
      st_r <= ST_IDLE;
      busy_r <= 1'b0;
      mwe_r <= 1'b0;
      mre_r <= 1'b0;
      uwe_r <= 1'b0;
      pcwe_r <= 1'b0;
      flwe_r <= 1'b0;
      pdwe_r <= 1'b0;
    end else if (clk_en) begin
      slice_first_r <= slice_first_nxt;
      slice_second_r <= slice_second_nxt;
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      mwe_r <= mwe_nxt;
      mre_r <= mre_nxt;
      uwe_r <= uwe_nxt;
      pcwe_r <= pcwe_nxt;
      flwe_r <= flwe_nxt;
      pdwe_r <= pdwe_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign wr_addr = waddr_r;
  assign wr_is_working = wwork_r;
  assign user_ptr_new = uptr_r;
  assign user_ptr_we = uwe_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = mwd_r;
  assign mem_we = mwe_r;
  assign mem_re = mre_r;
  assign pc_load = pcl_r;
  assign pc_load_we = pcwe_r;
  assign flags_load = fl_r;
  assign flags_load_we = flwe_r;
  assign pop_data = pd_r;
  assign pop_data_we = pdwe_r;
  assign stk_busy = busy_r;
endmodule : wrs_core

/* verif/wrs_core_properties.sv */
// checker for the working register and stack block
`timescale 1ns/1ps
module wrs_core_properties (
  input wire logic clk, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [7:0] wr_operand, // operand
  input wire logic wr_short, // 4-bit form
  input wire logic [7:0] wr_addr, // resolved address
  input wire logic wr_is_working, // working flag
  input wire logic [3:0] stk_op, // stack request
  input wire logic [15:0] stk_pc, // pc to save
  input wire logic stk_busy, // sequence running
  input wire logic [15:0] mem_addr, // stack address
  input wire logic [7:0] mem_wdata, // stack write data
  input wire logic mem_we, // stack write
  input wire logic mem_re, // stack read
  input wire logic pc_load_we, // pc restore pulse
  input wire logic flags_load_we // flags restore pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic call_go; // call accepted this cycle
  logic [15:0] pc_cap_r; // pc of the last accepted call
  assign call_go = !stk_busy && stk_op == wrs_pkg::WRS_OP_CALL;
  // hold the pc so the pushes can be compared after the request is gone
  always_ff @(posedge clk) begin
    if (call_go) pc_cap_r <= stk_pc;
  end
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  property p_plain;
    !wr_short && wr_operand[7:4] != 4'hC |=> wr_addr == $past(wr_operand) && !wr_is_working;
  endproperty
  property p_work; wr_short || wr_operand[7:4] == 4'hC |=> wr_is_working; endproperty
  property p_low3; wr_is_working |-> wr_addr[2:0] == $past(wr_operand[2:0]); endproperty
  property p_push_dec; mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 16'h0001;
  endproperty
  property p_call;
    call_go |-> ##[1:3] (mem_we && mem_wdata == pc_cap_r[7:0])
      ##1 (mem_we && mem_wdata == pc_cap_r[15:8]);
  endproperty
  property p_rst_idle; !$past(rst_b) |-> !stk_busy && !mem_we && !mem_re; endproperty
  property p_int_return; flags_load_we |-> ##[0:6] pc_load_we; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_plain: assert property (p_plain) else $error("plain operand altered");
  a_work: assert property (p_work) else $error("working operand missed");
  a_low3: assert property (p_low3) else $error("low address bits wrong");
  a_push_dec: assert property (p_push_dec) else $error("push not predecrement");
  a_call: assert property (p_call) else $error("call pushes wrong");
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  a_int_return: assert property (p_int_return) else $error("flags without pc");
  c_call: cover property (call_go);
  c_int_return: cover property (flags_load_we);
  c_pop: cover property (mem_re);
endmodule : wrs_core_properties
bind wrs_core wrs_core_properties chk_u (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wr_operand(wr_operand), .wr_short(wr_short), .wr_addr(wr_addr),
  .wr_is_working(wr_is_working), .stk_op(stk_op), .stk_pc(stk_pc), .stk_busy(stk_busy),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
  .pc_load_we(pc_load_we), .flags_load_we(flags_load_we));

/* verif/wrs_core_test.sv */
// self-checking bench for the working register and stack block
`timescale 1ns/1ps
module wrs_core_test;
  logic clk = 1'b0; // core clock
  logic rst_b = 1'b0; // reset, active low
  logic clk_en = 1'b1; // held on, freeze not exercised
  logic reg_wr = 1'b0, reg_rd = 1'b0, wr_short = 1'b0; // strobes and form
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, wr_operand = 8'h00; // bus and operand
  logic [3:0] stk_op = 4'h0; // stack request
  logic [15:0] stk_pc = 16'h0000; // pc to save
  logic [7:0] stk_flags = 8'h00, stk_data = 8'h00, user_ptr = 8'h00, mem_rdata = 8'h00;
  logic [7:0] reg_rdata, wr_addr, user_ptr_new, mem_wdata, flags_load, pop_data; // outputs
  logic [15:0] mem_addr, pc_load; // outputs
  logic wr_is_working, user_ptr_we, mem_we, mem_re, pc_load_we, flags_load_we; // outputs
  logic pop_data_we, stk_busy; // outputs
  logic [7:0] mem [0:65535]; // stack memory beside the block
  logic [15:0] wa_q[$]; // addresses written, oldest first
  logic [15:0] got_pc; // captured results
  logic [7:0] got_fl, got_pop, got_up;
  int num_errors = 0, compares = 0, cycles = 0;
  wrs_core dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wr_operand(wr_operand), .wr_short(wr_short), .wr_addr(wr_addr),
    .wr_is_working(wr_is_working), .stk_op(stk_op), .stk_pc(stk_pc), .stk_flags(stk_flags),
    .stk_data(stk_data), .user_ptr(user_ptr), .user_ptr_new(user_ptr_new),
    .user_ptr_we(user_ptr_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_load_we(pc_load_we),
    .flags_load(flags_load), .flags_load_we(flags_load_we), .pop_data(pop_data),
    .pop_data_we(pop_data_we), .stk_busy(stk_busy));
  initial begin
    forever #50 clk = ~clk;
  end
  // memory model and pulse capture; idle read data is inverted so stale bytes never match
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (mem_we) wa_q.push_back(mem_addr);
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    if (pc_load_we) got_pc <= pc_load;
    if (flags_load_we) got_fl <= flags_load;
    if (pop_data_we) got_pop <= pop_data;
    if (user_ptr_we) got_up <= user_ptr_new;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd_chk
  // one request, then wait for the sequence and its trailing pulses
  task automatic do_op(input logic [3:0] op, input logic [15:0] pc, input logic [7:0] d);
    int i;
    @(posedge clk);
    stk_op <= op;
    stk_pc <= pc;
    stk_flags <= ~d;
    stk_data <= d;
    @(posedge clk);
    stk_op <= 4'h0;
    @(negedge clk); // busy is only settled after the accepting edge
    for (i = 0; i < 20 && stk_busy !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : do_op
  function automatic logic [7:0] exp_addr(input logic [7:0] op, input logic s,
      input logic [7:0] a, input logic [7:0] b);
    if (s || op[7:4] == 4'hC) return {op[3] ? b[7:3] : a[7:3], op[2:0]};
    return op;
  endfunction : exp_addr
  initial begin
    logic [7:0] p1, p2, op, v;
    logic [15:0] pc;
    logic s;
    int r, k;
    p1 = 8'($urandom(32'hd25e));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("first pointer", wrs_pkg::ADDR_SLICE_FIRST, 8'hC0);
    rd_chk("second pointer", wrs_pkg::ADDR_SLICE_SECOND, 8'hC8);
    rd_chk("unmapped read", 8'h55, 8'h00);
    // random pointers, low bits kept on read but unused for addressing
    for (r = 0; r < 3; r++) begin
      p1 = 8'($urandom);
      p2 = 8'($urandom);
      wr_reg(wrs_pkg::ADDR_SLICE_FIRST, p1);
      wr_reg(wrs_pkg::ADDR_SLICE_SECOND, p2);
      rd_chk("first pointer", wrs_pkg::ADDR_SLICE_FIRST, p1);
      rd_chk("second pointer", wrs_pkg::ADDR_SLICE_SECOND, p2);
      for (k = 0; k < 12; k++) begin
        op = 8'($urandom);
        s = 1'($urandom);
        if (k % 3 == 0) op[7:4] = 4'hC;
        @(posedge clk);
        wr_operand <= op;
        wr_short <= s;
        @(posedge clk);
        @(negedge clk);
        chk("resolved address", {8'h00, exp_addr(op, s, p1, p2)}, {8'h00, wr_addr});
        chk("working flag", {15'h0000, s || op[7:4] == 4'hC}, {15'h0000, wr_is_working});
      end
    end
    v = 8'($urandom);
    wr_reg(wrs_pkg::ADDR_SP_HIGH, v);
    rd_chk("high byte storage", wrs_pkg::ADDR_SP_HIGH, v);
    wr_reg(wrs_pkg::ADDR_SP_HIGH, 8'h12);
    wr_reg(wrs_pkg::ADDR_SP_LOW, 8'h00);
    rd_chk("stack low", wrs_pkg::ADDR_SP_LOW, 8'h00);
    pc = 16'($urandom);
    wa_q.delete();
    do_op(wrs_pkg::WRS_OP_CALL, pc, 8'h00);
    chk("first push address", 16'h11FF, wa_q[0]);
    chk("pushed pc", pc, {mem[16'h11FE], mem[16'h11FF]});
    rd_chk("high after borrow", wrs_pkg::ADDR_SP_HIGH, 8'h11);
    do_op(wrs_pkg::WRS_OP_RET, 16'h0000, 8'h00);
    chk("returned pc", pc, got_pc);
    rd_chk("high after carry", wrs_pkg::ADDR_SP_HIGH, 8'h12);
    pc = 16'($urandom);
    v = 8'($urandom);
    do_op(wrs_pkg::WRS_OP_INT, pc, v);
    do_op(wrs_pkg::WRS_OP_INT_RETURN, 16'h0000, 8'h00);
    chk("interrupt pc", pc, got_pc);
    chk("interrupt flags", {8'h00, ~v}, {8'h00, got_fl});
    do_op(wrs_pkg::WRS_OP_PUSH, 16'h0000, v);
    do_op(wrs_pkg::WRS_OP_POP, 16'h0000, 8'h00);
    chk("popped byte", {8'h00, v}, {8'h00, got_pop});
    rd_chk("stack low restored", wrs_pkg::ADDR_SP_LOW, 8'h00);
    // user stacks: increment and decrement variants of push and pop
    for (k = 0; k < 4; k++) begin
      v = 8'($urandom);
      op = 8'($urandom);
      mem[{8'h00, v}] = op;
      wa_q.delete();
      @(posedge clk);
      user_ptr <= v;
      p1 = (k % 2 == 0) ? v + 8'h01 : v - 8'h01;
      do_op(4'(k + 7), 16'h0000, op);
      chk("user pointer", {8'h00, p1}, {8'h00, got_up});
      if (k < 2) chk("user push address", {8'h00, p1}, {8'h00, wa_q[0][7:0]});
      else chk("user pop data", {8'h00, op}, {8'h00, got_pop});
    end
    // low byte started at FFH, so a push never borrows into the stored high byte
    wr_reg(wrs_pkg::ADDR_SP_LOW, 8'hFF);
    do_op(wrs_pkg::WRS_OP_PUSH, 16'h0000, v);
    rd_chk("high kept as storage", wrs_pkg::ADDR_SP_HIGH, 8'h12);
    rd_chk("low after push", wrs_pkg::ADDR_SP_LOW, 8'hFE);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("pointer after reset", wrs_pkg::ADDR_SLICE_SECOND, 8'hC8);
    stop_test();
  end
endmodule : wrs_core_test
